/* File: logic/pbo_port_override.sv */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "pbo_map.svh"

//                      Function
// R01: Software sets pin 2 direction before compare-A waveform shows on pin 2.
// R02: Programmed clock-output fuse drives system clock on pin 2, ignoring latch/direction.
// R03: Clock output on pin 2 continues while device is held in reset.
// R04: Pin 3 is active-low reset input while reset-disable fuse reads one.
// R05: As reset input, pin 3 has pull-up, no driver, no digital input.
// R06: Debug link active only with debug fuse programmed and all locks unprogrammed.
// R07: Active debug makes pin 3 open-drain bidirectional with pull-up.
// R08: Pin 2 value is clock when clock output, else compare-A output.
// R09: Pin 2 input forced on by source ten with group 1, or irq zero.
// R10: Crystal clock source takes pins 0 and 1: no pull-up, driver, value.
// R11: External clock source overrides pin 0 only; pin 1 stays ordinary I/O.
// R12: Pins 2 and 3 are pin-change sources ten and eleven, group 1.
// R13: Global pull-up disable turns off every port pull-up; pin 3 keeps its pull-up while reset pin or debug link is active.
// R14: Control register bits 7 and 2 always read zero.
// R15: Input register reads return synchronized pin levels, not latch contents.

module pbo_port_override
    import pbo_pkg::*;
#(
    parameter int PA_W   = 8,
    parameter int PB_W   = 4,
    parameter int LOCK_W = 2
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic [5:0]        regAddr,
    input  wire logic [7:0]        regWrData,
    input  wire logic              regWrEn,
    input  wire logic              regRdEn,
    output logic      [7:0]        regRdData,
    input  wire logic [PA_W-1:0]   padInA,
    output logic      [PA_W-1:0]   padOutA,
    output logic      [PA_W-1:0]   padOeA,
    output logic      [PA_W-1:0]   padPullA,
    input  wire logic [PB_W-1:0]   padInB,
    output logic      [PB_W-1:0]   padOutB,
    output logic      [PB_W-1:0]   padOeB,
    output logic      [PB_W-1:0]   padPullB,
    input  wire logic              clockOutputFuse,
    input  wire logic              resetPinDisableFuse,
    input  wire logic              debugLinkEnableFuse,
    input  wire logic [LOCK_W-1:0] lockBits,
    input  wire logic              crystalClockSelected,
    input  wire logic              externalClockSelected,
    input  wire logic              timerCompareAEnable,
    input  wire logic              timerCompareAOutput,
    input  wire logic              externalIrqZeroEnable,
    input  wire logic              pinChangeGroup1Enable,
    input  wire logic [PB_W-1:0]   pinChangeMaskB,
    input  wire logic              debugTransmit,
    output logic                   oneWireDebugActive,
    output logic                   oneWireDebugRx,
    output logic                   externalResetReq,
    output logic      [PB_W-1:0]   pinChangeLevelB
);

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    if (PB_W != 4) begin : g_bad_pbw
        $error("pbo_port_override: port B override logic serves exactly four pins");
    end
    if (PA_W < 1 || PA_W > 8 || LOCK_W < 1) begin : g_bad_w
        $error("pbo_port_override: port A width must be 1..8, lock width at least 1");
    end

    // ----------------------------------------
    // Registers and decode
    // ----------------------------------------
    logic [PA_W-1:0] dirA_r;
    logic [PA_W-1:0] latchA_r;
    logic [PB_W-1:0] dirB_r;
    logic [PB_W-1:0] latchB_r;
    logic [3:0]      mcuCtl_r;
    logic [PA_W-1:0] syncA1_r;
    logic [PA_W-1:0] syncA2_r;
    logic [PB_W-1:0] syncB1_r;
    logic [PB_W-1:0] syncB2_r;
    logic [7:0]      rdData_r;
    logic [7:0]      rdData_nxt;
    logic [PA_W-1:0] inEnA;
    logic [PB_W-1:0] inEnB;
    logic [PB_W-1:0] pullOvrEnB;
    logic [PB_W-1:0] pullOvrValB;
    logic [PB_W-1:0] dirOvrEnB;
    logic [PB_W-1:0] dirOvrValB;
    logic [PB_W-1:0] valOvrEnB;
    logic [PB_W-1:0] valOvrValB;
    logic [PB_W-1:0] inOvrEnB;
    logic [PB_W-1:0] inOvrValB;
    logic            pullOffBit;
    logic            clockOutActive;
    logic            resetPinActive;
    pbo_sel_e        wrSel;
    pbo_sel_e        rdSel;

    assign wrSel  = regWrEn ? pbo_decode(regAddr) : PBO_SEL_NONE;
    assign rdSel  = regRdEn ? pbo_decode(regAddr) : PBO_SEL_NONE;
    assign pullOffBit = mcuCtl_r[`PBO_MCU_PULLOFF_BIT-3];

    // Port A direction and latch
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            dirA_r   <= PA_W'(`PBO_RST_BYTE);
            latchA_r <= PA_W'(`PBO_RST_BYTE);
        end else begin
            if (wrSel == PBO_SEL_PA_DIR) begin
                dirA_r <= regWrData[PA_W-1:0];
            end
            if (wrSel == PBO_SEL_PA_LAT) begin
                latchA_r <= regWrData[PA_W-1:0];
            end
        end
    end

    // Port B direction and latch, low nibble writable
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            dirB_r   <= PB_W'(`PBO_RST_BYTE);
            latchB_r <= PB_W'(`PBO_RST_BYTE);
        end else begin
            if (wrSel == PBO_SEL_PB_DIR) begin
                dirB_r <= regWrData[PB_W-1:0];
            end
            if (wrSel == PBO_SEL_PB_LAT) begin
                latchB_r <= regWrData[PB_W-1:0];
            end
        end
    end

    // Control register, bits 6..3 writable
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mcuCtl_r <= 4'h0;
        end else if (wrSel == PBO_SEL_MCU) begin
            mcuCtl_r <= regWrData[6:3];
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // No reset: pins stay tracked, so no false low on reset pin
    always_ff @(posedge core_clk) begin
        syncA1_r <= padInA;
        syncA2_r <= syncA1_r;
        syncB1_r <= padInB;
        syncB2_r <= syncB1_r;
    end

    // ----------------------------------------
    // Port B override terms
    // ----------------------------------------
    // R06: debug gate
    assign oneWireDebugActive = ~debugLinkEnableFuse & (&lockBits);
    // R02: fuse programmed reads zero
    assign clockOutActive     = ~clockOutputFuse;
    // R04: reset function while fuse unprogrammed
    assign resetPinActive     = resetPinDisableFuse & ~oneWireDebugActive;

    always_comb begin
        pullOvrEnB  = '0;
        pullOvrValB = '0;
        dirOvrEnB   = '0;
        dirOvrValB  = '0;
        valOvrEnB   = '0;
        valOvrValB  = '0;
        inOvrEnB    = '0;
        inOvrValB   = '0;
        // R10: crystal takes pins 0 and 1
        if (crystalClockSelected) begin
            pullOvrEnB[1:0] = 2'h3;
            dirOvrEnB[1:0]  = 2'h3;
            valOvrEnB[1:0]  = 2'h3;
            inOvrEnB[1:0]   = 2'h3;
        // R11: external clock takes pin 0 only
        end else if (externalClockSelected) begin
            pullOvrEnB[0] = 1'b1;
            dirOvrEnB[0]  = 1'b1;
            valOvrEnB[0]  = 1'b1;
            inOvrEnB[0]   = 1'b1;
            inOvrValB[0]  = 1'b1;
        end
        // R12: pins 0/1 as group 1 sources when not taken
        for (int i = 0; i < 2; i++) begin
            if (!inOvrEnB[i]) begin
                inOvrEnB[i]  = pinChangeGroup1Enable & pinChangeMaskB[i];
                inOvrValB[i] = pinChangeGroup1Enable & pinChangeMaskB[i];
            end
        end
        // R02 R03: clock drives pin, in reset too
        pullOvrEnB[2] = clockOutActive;
        dirOvrEnB[2]  = clockOutActive;
        dirOvrValB[2] = 1'b1;
        // R01: compare output overrides value only, direction stays software's
        // R08: clock wins over compare-A
        valOvrEnB[2]  = clockOutActive | timerCompareAEnable;
        valOvrValB[2] = clockOutActive ? core_clk : timerCompareAOutput;
        // R09: input forced on for irq zero or source ten
        inOvrEnB[2]  = externalIrqZeroEnable | (pinChangeMaskB[2] & pinChangeGroup1Enable);
        inOvrValB[2] = inOvrEnB[2];
        // R05: reset pin pull-up, no driver, no digital input
        // R07: debug pin open-drain with pull-up
        pullOvrEnB[3]  = resetPinActive | oneWireDebugActive;
        pullOvrValB[3] = 1'b1;
        dirOvrEnB[3]   = pullOvrEnB[3];
        dirOvrValB[3]  = oneWireDebugActive & debugTransmit;
        valOvrEnB[3]   = pullOvrEnB[3];
        valOvrValB[3]  = 1'b0;
        inOvrEnB[3]    = pullOvrEnB[3] | (pinChangeMaskB[3] & pinChangeGroup1Enable);
        inOvrValB[3]   = oneWireDebugActive
                       | (~resetPinActive & pinChangeMaskB[3] & pinChangeGroup1Enable);
    end

    // ----------------------------------------
    // Pin cells
    // ----------------------------------------
    // R13: global pull-up disable into every cell
    for (genvar a = 0; a < PA_W; a++) begin : g_pin_a
        pbo_pin_cell u_cell (
            .outputLatchBit            (latchA_r[a]),
            .directionBit              (dirA_r[a]),
            .globalPullupDisable       (pullOffBit),
            .pullupOverrideEnable      (1'b0),
            .pullupOverrideValue       (1'b0),
            .directionOverrideEnable   (1'b0),
            .directionOverrideValue    (1'b0),
            .outputValueOverrideEnable (1'b0),
            .outputValueOverrideValue  (1'b0),
            .inputEnableOverrideEnable (1'b0),
            .inputEnableOverrideValue  (1'b0),
            .padOut                    (padOutA[a]),
            .padOe                     (padOeA[a]),
            .padPullup                 (padPullA[a]),
            .inputEnable               (inEnA[a])
        );
    end

    for (genvar b = 0; b < PB_W; b++) begin : g_pin_b
        pbo_pin_cell u_cell (
            .outputLatchBit            (latchB_r[b]),
            .directionBit              (dirB_r[b]),
            .globalPullupDisable       (pullOffBit),
            .pullupOverrideEnable      (pullOvrEnB[b]),
            .pullupOverrideValue       (pullOvrValB[b]),
            .directionOverrideEnable   (dirOvrEnB[b]),
            .directionOverrideValue    (dirOvrValB[b]),
            .outputValueOverrideEnable (valOvrEnB[b]),
            .outputValueOverrideValue  (valOvrValB[b]),
            .inputEnableOverrideEnable (inOvrEnB[b]),
            .inputEnableOverrideValue  (inOvrValB[b]),
            .padOut                    (padOutB[b]),
            .padOe                     (padOeB[b]),
            .padPullup                 (padPullB[b]),
            .inputEnable               (inEnB[b])
        );
    end

    // ----------------------------------------
    // Pin-facing status outputs
    // ----------------------------------------
    // R12: gated levels feed group 1 sources
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pinChangeLevelB <= '0;
        end else begin
            pinChangeLevelB <= syncB2_r & inEnB;
        end
    end

    // R04: low level on pin 3 requests reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            externalResetReq <= 1'b0;
            oneWireDebugRx   <= 1'b1;
        end else begin
            externalResetReq <= resetPinActive & ~syncB2_r[3];
            oneWireDebugRx   <= oneWireDebugActive ? syncB2_r[3] : 1'b1;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        rdData_nxt = 8'h00;
        case (rdSel)
            // R15: pin levels, not latches
            PBO_SEL_PA_IN:  rdData_nxt = 8'(syncA2_r & inEnA);
            PBO_SEL_PINB:   rdData_nxt = 8'(syncB2_r & inEnB);
            PBO_SEL_PA_DIR: rdData_nxt = 8'(dirA_r);
            PBO_SEL_PA_LAT: rdData_nxt = 8'(latchA_r);
            PBO_SEL_PB_DIR: rdData_nxt = 8'(dirB_r);
            PBO_SEL_PB_LAT: rdData_nxt = 8'(latchB_r);
            // R14: bits 7 and 2 read zero
            PBO_SEL_MCU:   rdData_nxt = {1'b0, mcuCtl_r, 3'h0};
            default:       rdData_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdData_r <= 8'h00;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_clock_output_fuse_drive: assert property (@(posedge core_clk) // R02 R03
        !clockOutputFuse |-> padOeB[2] && !padPullB[2])
        else $error("clock output does not drive pin 2");

    a_cmpa_value: assert property (@(posedge core_clk) disable iff (!nrst) // R08
        clockOutputFuse && timerCompareAEnable |-> padOutB[2] == timerCompareAOutput && padOeB[2] == dirB_r[2])
        else $error("compare-A value or direction wrong on pin 2");

    a_reset_pin_off: assert property (@(posedge core_clk) disable iff (!nrst) // R05
        resetPinDisableFuse && !oneWireDebugActive |-> padPullB[3] && !padOeB[3] && !inEnB[3])
        else $error("reset pin not configured as input with pull-up");

    a_reset_request: assert property (@(posedge core_clk) disable iff (!nrst) // R04
        (resetPinDisableFuse && debugLinkEnableFuse && !padInB[3]) [*4] |-> externalResetReq)
        else $error("low reset pin gave no reset request");

    a_debug_opendrain: assert property (@(posedge core_clk) disable iff (!nrst) // R07
        oneWireDebugActive |-> !padOutB[3] && padPullB[3] && (padOeB[3] == debugTransmit))
        else $error("debug pin not open-drain");

    a_debug_gate: assert property (@(posedge core_clk) disable iff (!nrst) // R06
        !(&lockBits) |-> !oneWireDebugActive && (padOeB[3] == 1'b0 || !resetPinDisableFuse))
        else $error("debug active with a lock bit programmed");

    a_pin2_input: assert property (@(posedge core_clk) disable iff (!nrst) // R09
        (externalIrqZeroEnable && padInB[2]) [*4] |-> pinChangeLevelB[2])
        else $error("pin 2 input not forced on");

    a_crystal_pins: assert property (@(posedge core_clk) disable iff (!nrst) // R10
        crystalClockSelected |-> padOeB[1:0] == 2'h0 && padPullB[1:0] == 2'h0 && padOutB[1:0] == 2'h0)
        else $error("crystal pins still under port control");

    a_extclk_pin1: assert property (@(posedge core_clk) disable iff (!nrst) // R11
        externalClockSelected && !crystalClockSelected |-> padOeB[1] == dirB_r[1] && !padOeB[0])
        else $error("external clock override wrong");

    a_pull_disable: assert property (@(posedge core_clk) disable iff (!nrst) // R13
        pullOffBit |-> padPullA == '0)
        else $error("pull-up active while globally disabled");

    a_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst) // R14
        regRdEn && regAddr == `PBO_OFS_MCUCTL |=> regRdData[7] == 1'b0 && regRdData[2] == 1'b0)
        else $error("reserved control bits read nonzero");

    a_pin_read: assert property (@(posedge core_clk) disable iff (!nrst) // R15
        regRdEn && regAddr == `PBO_OFS_PA_IN |=> regRdData[PA_W-1:0] == $past(padInA, 3))
        else $error("port A input read mismatch");

endmodule : pbo_port_override

/* File: logic/pbo_map.svh */
`ifndef PBO_MAP_SVH
`define PBO_MAP_SVH

// ----------------------------------------
// Register offsets (I/O space index)
// ----------------------------------------
`define PBO_OFS_PINB      6'h16
`define PBO_OFS_PB_DIR    6'h17
`define PBO_OFS_PB_LAT    6'h18
`define PBO_OFS_PA_IN     6'h19
`define PBO_OFS_PA_DIR    6'h1A
`define PBO_OFS_PA_LAT    6'h1B
`define PBO_OFS_MCUCTL    6'h1C

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define PBO_MCU_PULLOFF_BIT 6
`define PBO_MCU_WR_MASK   8'h78
`define PBO_PB_WR_MASK    8'h0F

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define PBO_RST_BYTE      8'h00
`define PBO_SYNC_STAGES   2

`endif

/* File: logic/pbo_pkg.sv */
package pbo_pkg;

    `include "pbo_map.svh"

    typedef logic [7:0] pbo_byte_t;

    // Register select decoded from the I/O address
    typedef enum logic [6:0] {
        PBO_SEL_NONE  = 7'h00,
        PBO_SEL_PINB  = 7'h01,
        PBO_SEL_PB_DIR = 7'h02,
        PBO_SEL_PB_LAT = 7'h04,
        PBO_SEL_PA_IN  = 7'h08,
        PBO_SEL_PA_DIR = 7'h10,
        PBO_SEL_PA_LAT = 7'h20,
        PBO_SEL_MCU   = 7'h40
    } pbo_sel_e;

    // Address to register select
    function automatic pbo_sel_e pbo_decode(input logic [5:0] addr);
        case (addr)
            `PBO_OFS_PINB:   pbo_decode = PBO_SEL_PINB;
            `PBO_OFS_PB_DIR: pbo_decode = PBO_SEL_PB_DIR;
            `PBO_OFS_PB_LAT: pbo_decode = PBO_SEL_PB_LAT;
            `PBO_OFS_PA_IN:  pbo_decode = PBO_SEL_PA_IN;
            `PBO_OFS_PA_DIR: pbo_decode = PBO_SEL_PA_DIR;
            `PBO_OFS_PA_LAT: pbo_decode = PBO_SEL_PA_LAT;
            `PBO_OFS_MCUCTL: pbo_decode = PBO_SEL_MCU;
            default:         pbo_decode = PBO_SEL_NONE;
        endcase
    endfunction : pbo_decode

endpackage : pbo_pkg

/* File: logic/pbo_pin_cell.sv */
`timescale 1ns/10ps

// ----------------------------------------
// One pin: alternate-function override mux
// ----------------------------------------
module pbo_pin_cell (
    input  wire logic outputLatchBit,
    input  wire logic directionBit,
    input  wire logic globalPullupDisable,
    input  wire logic pullupOverrideEnable,
    input  wire logic pullupOverrideValue,
    input  wire logic directionOverrideEnable,
    input  wire logic directionOverrideValue,
    input  wire logic outputValueOverrideEnable,
    input  wire logic outputValueOverrideValue,
    input  wire logic inputEnableOverrideEnable,
    input  wire logic inputEnableOverrideValue,
    output logic      padOut,
    output logic      padOe,
    output logic      padPullup,
    output logic      inputEnable
);

    // Pull-up: input with latch high, unless globally disabled
    assign padPullup = pullupOverrideEnable ? pullupOverrideValue
                     : (~directionBit & outputLatchBit & ~globalPullupDisable);

    // Driver and value
    assign padOe   = directionOverrideEnable   ? directionOverrideValue   : directionBit;
    assign padOut  = outputValueOverrideEnable ? outputValueOverrideValue : outputLatchBit;

    // Digital input path
    assign inputEnable = inputEnableOverrideEnable ? inputEnableOverrideValue : 1'b1;

endmodule : pbo_pin_cell

/* File: bench/pbo_pin_board.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Board circuitry on the port pins
// ----------------------------------------
module pbo_pin_board #(
    parameter int PA_W = 8,
    parameter int PB_W = 4
) (
    input  wire logic            core_clk,
    input  wire logic [PA_W-1:0] padOutA,
    input  wire logic [PA_W-1:0] padOeA,
    input  wire logic [PA_W-1:0] padPullA,
    input  wire logic [PB_W-1:0] padOutB,
    input  wire logic [PB_W-1:0] padOeB,
    input  wire logic [PB_W-1:0] padPullB,
    input  wire logic [PA_W-1:0] boardOeA,
    input  wire logic [PA_W-1:0] boardValA,
    input  wire logic [PB_W-1:0] boardOeB,
    input  wire logic [PB_W-1:0] boardValB,
    output logic      [PA_W-1:0] padInA,
    output logic      [PB_W-1:0] padInB
);
    logic [PA_W-1:0] float_r = '0;
    // Undriven pins without pull-up wander every cycle
    always @(posedge core_clk) begin
        float_r <= ~float_r;
    end
    // Wire level: device driver first, then board, then pull-up
    always_comb begin
        for (int i = 0; i < PA_W; i++) begin
            padInA[i] = padOeA[i] ? padOutA[i] : boardOeA[i] ? boardValA[i] : padPullA[i] | float_r[i];
        end
        for (int i = 0; i < PB_W; i++) begin
            padInB[i] = padOeB[i] ? padOutB[i] : boardOeB[i] ? boardValB[i] : padPullB[i] | float_r[i];
        end
    end
endmodule : pbo_pin_board

/* File: bench/port_b_alt_function_override_tb_top.sv */
`timescale 1ns/10ps
`include "pbo_map.svh"
module port_b_alt_function_override_tb_top;
    // ----------------------------------------
    // Design, pin board and bench tasks
    // ----------------------------------------
    logic       core_clk, dbgActive, dbgRx, rstReq;
    logic       nrst = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, ckFuse = 1'b1, rstFuse = 1'b0, dbgFuse = 1'b1;
    logic       xtalSel = 1'b0, extSel = 1'b0, cmpEn = 1'b0, cmpOut = 1'b0, irq0En = 1'b0, grpEn = 1'b0, dbgTx = 1'b0;
    logic [1:0] locks = 2'h3;
    logic [5:0] regAddr = 6'h00;
    logic [7:0] regWrData = 8'h00, bOeA = 8'h00, bValA = 8'h00, regRdData, padInA, padOutA, padOeA, padPullA;
    logic [3:0] pcMask = 4'h0, bOeB = 4'h0, bValB = 4'h0, padInB, padOutB, padOeB, padPullB, pcLevel;
    int         fails = 0;
    int         checkCount = 0;
    int         cycles = 0;
    pbo_port_override dut (
        .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .padInA(padInA), .padOutA(padOutA), .padOeA(padOeA),
        .padPullA(padPullA), .padInB(padInB), .padOutB(padOutB), .padOeB(padOeB), .padPullB(padPullB),
        .clockOutputFuse(ckFuse), .resetPinDisableFuse(rstFuse), .debugLinkEnableFuse(dbgFuse), .lockBits(locks),
        .crystalClockSelected(xtalSel), .externalClockSelected(extSel), .timerCompareAEnable(cmpEn),
        .timerCompareAOutput(cmpOut), .externalIrqZeroEnable(irq0En), .pinChangeGroup1Enable(grpEn),
        .pinChangeMaskB(pcMask), .debugTransmit(dbgTx), .oneWireDebugActive(dbgActive), .oneWireDebugRx(dbgRx),
        .externalResetReq(rstReq), .pinChangeLevelB(pcLevel)
    );
    pbo_pin_board board (
        .core_clk(core_clk), .padOutA(padOutA), .padOeA(padOeA), .padPullA(padPullA), .padOutB(padOutB),
        .padOeB(padOeB), .padPullB(padPullB), .boardOeA(bOeA), .boardValA(bValA), .boardOeB(bOeB),
        .boardValB(bValB), .padInA(padInA), .padInB(padInB)
    );
    // Clock of 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            wrapUp();
        end
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task wrapUp();
        $display("Comparisons %0d, mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrapUp
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge core_clk);
        regWrEn   <= 1'b0;
    endtask : wr
    task rdChk(input logic [5:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #10;
        check(regRdData, exp);
    endtask : rdChk
    task step(input int n);
        repeat (n) @(posedge core_clk);
        #10;
    endtask : step
    task tRegs();
        rdChk(`PBO_OFS_PB_DIR, 8'h00);
        wr(`PBO_OFS_MCUCTL, 8'hFF);
        rdChk(`PBO_OFS_MCUCTL, 8'h78);
        step(1);
        check(regRdData, 8'h00);
        wr(`PBO_OFS_MCUCTL, 8'h00);
        wr(`PBO_OFS_PB_LAT, 8'hFF);
        rdChk(`PBO_OFS_PB_LAT, 8'h0F);
        rdChk(6'h00, 8'h00);
        wr(`PBO_OFS_PB_LAT, 8'h02);
    endtask : tRegs
    task tPortA();
        @(posedge core_clk);
        bOeA  <= 8'hFF;
        bValA <= 8'hA5;
        wr(`PBO_OFS_PA_LAT, 8'h3C);
        step(3);
        rdChk(`PBO_OFS_PA_IN, 8'hA5);
        check({padPullA[3:0], padPullB}, 8'hC2);
        wr(`PBO_OFS_MCUCTL, 8'h40);
        step(1);
        check({padPullA[3:0], padPullB}, 8'h00);
        wr(`PBO_OFS_MCUCTL, 8'h00);
        // Port A driver, value and readback
        wr(`PBO_OFS_PA_DIR, 8'h0F);
        rdChk(`PBO_OFS_PA_LAT, 8'h3C);
        check({padOeA[3:0], padOutA[3:0]}, 8'hFC);
        rdChk(`PBO_OFS_PA_DIR, 8'h0F);
    endtask : tPortA
    task clkPhases();
        step(1);
        check({6'h0, padOeB[2], padOutB[2]}, 8'h03);
        @(negedge core_clk);
        #10;
        check({6'h0, padOeB[2], padOutB[2]}, 8'h02);
    endtask : clkPhases
    task tClock();
        @(posedge core_clk);
        cmpEn  <= 1'b1;
        cmpOut <= 1'b1;
        step(1);
        check({6'h0, padOeB[2], padOutB[2]}, 8'h01);
        wr(`PBO_OFS_PB_DIR, 8'h04);
        step(1);
        check({6'h0, padOeB[2], padOutB[2]}, 8'h03);
        @(posedge core_clk);
        cmpOut <= 1'b0;
        ckFuse <= 1'b0;
        wr(`PBO_OFS_PB_DIR, 8'h00);
        clkPhases();
        @(posedge core_clk);
        nrst <= 1'b0;
        clkPhases();
        @(posedge core_clk);
        nrst   <= 1'b1;
        ckFuse <= 1'b1;
        cmpEn  <= 1'b0;
    endtask : tClock
    task tResetPin();
        @(posedge core_clk);
        rstFuse <= 1'b1;
        pcMask  <= 4'hF;
        grpEn   <= 1'b1;
        bOeB    <= 4'hF;
        bValB   <= 4'hF;
        wr(`PBO_OFS_PB_DIR, 8'h08);
        step(4);
        check({5'h0, padOeB[3], padPullB[3], rstReq}, 8'h02);
        check({4'h0, pcLevel}, 8'h07);
        @(posedge core_clk);
        bValB <= 4'h7;
        step(4);
        check({7'h0, rstReq}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            dbgFuse <= 1'b0;
            locks   <= 2'(i);
            step(1);
            check({7'h0, dbgActive}, (i == 3) ? 8'h01 : 8'h00);
        end
        @(posedge core_clk);
        dbgTx <= 1'b1;
        bOeB  <= 4'h7;
        step(1);
        check({6'h0, padOeB[3], padOutB[3]}, 8'h02);
        @(posedge core_clk);
        dbgTx <= 1'b0;
        step(4);
        check({5'h0, padOeB[3], padPullB[3], dbgRx}, 8'h03);
        @(posedge core_clk);
        bOeB <= 4'hF;
        step(4);
        check({7'h0, dbgRx}, 8'h00);
        @(posedge core_clk);
        rstFuse <= 1'b0;
        dbgFuse <= 1'b1;
        wr(`PBO_OFS_PB_DIR, 8'h00);
    endtask : tResetPin
    task tPinChange();
        @(posedge core_clk);
        pcMask <= 4'hC;
        bValB  <= 4'hA;
        step(4);
        check({4'h0, pcLevel}, 8'h0A);
        @(posedge core_clk);
        pcMask <= 4'h0;
        grpEn  <= 1'b0;
        irq0En <= 1'b1;
        bValB  <= 4'h4;
        step(4);
        check({7'h0, pcLevel[2]}, 8'h01);
    endtask : tPinChange
    task tCrystal();
        @(posedge core_clk);
        bOeB    <= 4'h0;
        xtalSel <= 1'b1;
        wr(`PBO_OFS_PB_DIR, 8'h02);
        wr(`PBO_OFS_PB_LAT, 8'h03);
        step(1);
        check({2'h0, padOeB[1:0], padPullB[1:0], padOutB[1:0]}, 8'h00);
        @(posedge core_clk);
        xtalSel <= 1'b0;
        extSel  <= 1'b1;
        step(1);
        check({3'h0, padOeB[1:0], padPullB[1:0], padOutB[1]}, 8'h11);
    endtask : tCrystal
    // Main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        tRegs();
        tPortA();
        tClock();
        tResetPin();
        tPinChange();
        tCrystal();
        wrapUp();
    end
endmodule : port_b_alt_function_override_tb_top
